/* dpr_host.sv */
// host controller driving one port of a two-port static memory
//
// Overview of operation
// - Select array with chip low, token high; flags opposite; hold through write end.
// - Host keeps rw high whenever address lines change.
// - Write pulse lengthened to turnoff plus setup while output drive is low.
// - Token request writes low on data bit zero, token select low.
// - Flag write ends with update pulse, then write-to-read gap before read.
// - Slave write keeps rw high the hold time after busy returns high.
`timescale 1ns/1ps
`include "dpr_params.svh"
module dpr_host #(
    parameter int AW = 14,
    parameter int DW = 16
) (
    // clock and reset
    input  wire logic          clk_i,
    input  wire logic          rst_b_i,
    // command side
    input  wire logic          req_valid_i,
    output logic               req_ready_o,
    input  wire logic [1:0]    req_cmd_i,
    input  wire logic [AW-1:0] req_addr_i,
    input  wire logic [DW-1:0] req_wdata_i,
    input  wire logic [1:0]    req_bytes_i,
    input  wire logic          req_oe_low_i,
    output logic               rsp_valid_o,
    output logic [DW-1:0]      rsp_rdata_o,
    output logic               rsp_token_o,
    // memory port pins
    output logic [AW-1:0]      addr_o,
    output logic               chip_select_n_o,
    output logic               token_select_n_o,
    output logic               read_not_write_o,
    output logic               output_drive_n_o,
    output logic               high_byte_select_n_o,
    output logic               low_byte_select_n_o,
    output logic [DW-1:0]      data_o,
    output logic [DW-1:0]      data_oe_o,
    input  wire logic [DW-1:0] data_i,
    input  wire logic          busy_n_i
);
    // ----------------------------------------------------------------
    // pin input synchronisers
    // ----------------------------------------------------------------
    logic [DW:0] pins_s;

    dpr_sync #(.W(DW + 1)) u_sync (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .d_i     ({~busy_n_i, data_i}),
        .q_o     (pins_s)
    );

    wire logic          busy_s  = pins_s[DW];   // busy high, reset reads idle
    wire logic [DW-1:0] rdata_s = pins_s[DW-1:0];

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    dpr_pkg::dpr_state_e state_r;
    dpr_pkg::dpr_cmd_e   cmd_r;
    logic [7:0]          cnt_r;
    logic [AW-1:0]       addr_r;
    logic [DW-1:0]       wdata_r;
    logic [1:0]          bytes_r;
    logic                oe_low_r;
    logic                was_busy_r;

    wire logic is_token = (cmd_r == dpr_pkg::DPR_CMD_TOKEN_GET) ||
                          (cmd_r == dpr_pkg::DPR_CMD_TOKEN_PUT);
    wire logic is_write = (cmd_r != dpr_pkg::DPR_CMD_READ);
    wire logic take     = (state_r == dpr_pkg::DPR_IDLE) && req_valid_i;

    // pulse length depends on output drive during rw controlled write
    wire logic [7:0] pulse_len = oe_low_r ?
        8'(`DPR_PULSE_OE_LO_CYC > `DPR_PULSE_OE_HI_CYC ?
           `DPR_PULSE_OE_LO_CYC : `DPR_PULSE_OE_HI_CYC) :
        8'(`DPR_PULSE_OE_HI_CYC);
    wire logic cnt_done = (cnt_r == 8'h00);

    // ----------------------------------------------------------------
    // pin decode
    // ----------------------------------------------------------------
    wire logic active = (state_r != dpr_pkg::DPR_IDLE) &&
                        (state_r != dpr_pkg::DPR_DONE) &&
                        (state_r != dpr_pkg::DPR_FLAG_GAP);
    // select asserted in setup, before rw falls
    wire logic sel_on = active && (state_r != dpr_pkg::DPR_RECOVER);
    wire logic wr_on  = is_write && (state_r == dpr_pkg::DPR_PULSE);
    // token writes put the value on bit zero and drive the other bits zero
    wire logic [DW-1:0] wvalue = is_token ?
        {{(DW-1){1'b0}}, cmd_r == dpr_pkg::DPR_CMD_TOKEN_PUT} : wdata_r;

    assign addr_o               = addr_r;
    assign chip_select_n_o      = ~(sel_on && !is_token);
    assign token_select_n_o     = ~(sel_on && is_token);
    assign read_not_write_o     = ~wr_on;
    assign output_drive_n_o     = ~((state_r == dpr_pkg::DPR_READ) ||
                                    (wr_on && oe_low_r));
    assign high_byte_select_n_o = ~(sel_on && (is_token || bytes_r[1]));
    assign low_byte_select_n_o  = ~(sel_on && (is_token || bytes_r[0]));
    assign data_o               = wvalue;
    assign data_oe_o            = {DW{wr_on}};
    assign req_ready_o          = (state_r == dpr_pkg::DPR_IDLE);

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    dpr_pkg::dpr_state_e state_nxt;
    logic [7:0]          cnt_nxt;

    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_done ? 8'h00 : cnt_r - 8'h01;
        case (state_r)
            dpr_pkg::DPR_IDLE: begin
                if (take) begin
                    state_nxt = dpr_pkg::DPR_SETUP;
                end
            end
            dpr_pkg::DPR_SETUP: begin
                // address settled with rw high before pulse starts
                if (is_write) begin
                    state_nxt = dpr_pkg::DPR_PULSE;
                    cnt_nxt   = pulse_len - 8'h01;
                end else begin
                    state_nxt = dpr_pkg::DPR_READ;
                    cnt_nxt   = 8'(`DPR_READ_CYC + 2);
                end
            end
            dpr_pkg::DPR_PULSE: begin
                if (busy_s && !is_token) begin
                    state_nxt = dpr_pkg::DPR_BUSY_WAIT;
                    cnt_nxt   = 8'(`DPR_SLAVE_HOLD_CYC);
                end else if (cnt_done) begin
                    state_nxt = dpr_pkg::DPR_RECOVER;
                    cnt_nxt   = 8'(`DPR_FLAG_UPDATE_CYC - 1);
                end
            end
            dpr_pkg::DPR_BUSY_WAIT: begin
                // rw stays high until hold after busy release
                if (busy_s) begin
                    cnt_nxt = 8'(`DPR_SLAVE_HOLD_CYC);
                end else if (cnt_done) begin
                    state_nxt = dpr_pkg::DPR_PULSE;
                    cnt_nxt   = pulse_len - 8'h01;
                end
            end
            dpr_pkg::DPR_RECOVER: begin
                if (cnt_done) begin
                    if (is_token) begin
                        state_nxt = dpr_pkg::DPR_FLAG_GAP;
                        cnt_nxt   = 8'(`DPR_FLAG_WR_RD_CYC - 1);
                    end else begin
                        state_nxt = dpr_pkg::DPR_DONE;
                    end
                end
            end
            dpr_pkg::DPR_FLAG_GAP: begin
                if (cnt_done) begin
                    state_nxt = dpr_pkg::DPR_READ;
                    cnt_nxt   = 8'(`DPR_READ_CYC + 2);
                end
            end
            dpr_pkg::DPR_READ: begin
                // extra wait if a collision delayed far data
                if (cnt_done) begin
                    if (was_busy_r) begin
                        cnt_nxt = 8'(`DPR_FAR_DATA_CYC);
                    end else begin
                        state_nxt = dpr_pkg::DPR_DONE;
                    end
                end
            end
            default: begin
                state_nxt = dpr_pkg::DPR_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_r <= dpr_pkg::DPR_IDLE;
            cnt_r   <= 8'h00;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    // ----------------------------------------------------------------
    // request capture
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cmd_r    <= dpr_pkg::DPR_CMD_READ;
            addr_r   <= '0;
            wdata_r  <= '0;
            bytes_r  <= 2'h0;
            oe_low_r <= 1'b0;
        end else if (take) begin
            cmd_r    <= dpr_pkg::dpr_cmd_e'(req_cmd_i);
            addr_r   <= req_addr_i;
            wdata_r  <= req_wdata_i;
            bytes_r  <= req_bytes_i;
            oe_low_r <= req_oe_low_i;
        end
    end

    // array reads or writes that saw busy, cleared on new request
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            was_busy_r <= 1'b0;
        end else if (take) begin
            was_busy_r <= 1'b0;
        end else if (busy_s && active && !is_token) begin
            was_busy_r <= 1'b1;
        end else if (state_r == dpr_pkg::DPR_READ && cnt_done) begin
            was_busy_r <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // response
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rsp_valid_o <= 1'b0;
            rsp_rdata_o <= '0;
            rsp_token_o <= 1'b0;
        end else begin
            rsp_valid_o <= (state_nxt == dpr_pkg::DPR_DONE);
            if (state_r == dpr_pkg::DPR_READ && cnt_done && !was_busy_r) begin
                rsp_rdata_o <= rdata_s;
                rsp_token_o <= is_token && !rdata_s[0];
            end
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_rw_addr_stable: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        !read_not_write_o |-> $stable(addr_o))
        else $error("address moved during write pulse");

    a_select_excl: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        !(~chip_select_n_o && ~token_select_n_o))
        else $error("array and token selected together");

    a_select_first: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        $fell(read_not_write_o) && !$past(wr_on) |->
        $past(!chip_select_n_o || !token_select_n_o))
        else $error("select not ahead of write");

    a_token_bit: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        !read_not_write_o && !token_select_n_o |-> data_oe_o[0] &&
        (data_o[DW-1:1] == '0))
        else $error("token write data wrong");

    a_pulse_width: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        $fell(read_not_write_o) && oe_low_r |-> !read_not_write_o [*2])
        else $error("write pulse too short");

    a_flag_gap: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        $rose(token_select_n_o) && is_token |=> token_select_n_o)
        else $error("flag update pulse too short");

    a_busy_hold: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        state_r == dpr_pkg::DPR_BUSY_WAIT && $fell(busy_s) |->
        read_not_write_o [*2])
        else $error("write during busy hold");

    a_byte_sel: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        !chip_select_n_o |-> (high_byte_select_n_o == !bytes_r[1]) &&
        (low_byte_select_n_o == !bytes_r[0]))
        else $error("byte selects wrong");
endmodule // dpr_host

/* dpr_mem_model.sv */
// behavioural model of one port of the two-port memory
`timescale 1ns/1ps
module dpr_mem_model (
    // write sampling clock
    input  wire logic        clk_i,
    // port pins
    input  wire logic [13:0] addr_i,
    input  wire logic        chip_select_n_i,
    input  wire logic        token_select_n_i,
    input  wire logic        read_not_write_i,
    input  wire logic        output_drive_n_i,
    input  wire logic        high_byte_select_n_i,
    input  wire logic        low_byte_select_n_i,
    input  wire logic [15:0] bus_i,
    output logic      [15:0] q_o,
    output logic             busy_n_o,
    // far port activity
    input  wire logic        far_active_i,
    input  wire logic [13:0] far_addr_i,
    input  wire logic [7:0]  far_claim_i
);
    logic [15:0] mem [0:16383];
    logic [7:0]  own_r;
    logic [15:0] last_r;
    logic        late_r;
    wire arr_sel  = !chip_select_n_i && token_select_n_i;
    wire flag_sel = chip_select_n_i && !token_select_n_i;
    wire byte_on  = !high_byte_select_n_i || !low_byte_select_n_i;
    wire wr_act   = (arr_sel || flag_sel) && !read_not_write_i && byte_on;
    wire rd_act   = (arr_sel || flag_sel) && read_not_write_i && !output_drive_n_i && !late_r;
    wire [15:0] rd_q = flag_sel ? {15'h7fff, !own_r[addr_i[2:0]]} : mem[addr_i];
    wire hi_on = rd_act && (flag_sel || !high_byte_select_n_i);
    wire lo_on = rd_act && (flag_sel || !low_byte_select_n_i);
    // released lanes toggle so a stale value never passes
    assign q_o = {hi_on ? rd_q[15:8] : ~last_r[15:8], lo_on ? rd_q[7:0] : ~last_r[7:0]};
    assign busy_n_o = !(far_active_i && arr_sel && far_addr_i == addr_i);
    initial begin
        foreach (mem[i]) mem[i] = 16'h0000;
        own_r = 8'h00;
        last_r = 16'h0000;
        late_r = 1'b0;
    end
    always @(negedge chip_select_n_i or negedge token_select_n_i) begin
        late_r = !read_not_write_i;
    end
    always @(posedge clk_i) begin
        last_r <= q_o;
        if (wr_act && arr_sel && busy_n_o) begin
            if (!high_byte_select_n_i) mem[addr_i][15:8] <= bus_i[15:8];
            if (!low_byte_select_n_i) mem[addr_i][7:0] <= bus_i[7:0];
        end
        if (wr_act && flag_sel) begin
            if (bus_i[0]) own_r[addr_i[2:0]] <= 1'b0;
            else if (!far_claim_i[addr_i[2:0]]) own_r[addr_i[2:0]] <= 1'b1;
        end
    end
endmodule // dpr_mem_model

/* dpr_params.svh */
// timing constants for the dual-port memory host controller
`ifndef DPR_PARAMS_SVH
`define DPR_PARAMS_SVH

// ----------------------------------------------------------------
// clock
// ----------------------------------------------------------------
`define DPR_CLK_PERIOD_NS        10

// ----------------------------------------------------------------
// times in ns
// ----------------------------------------------------------------
`define DPR_WRITE_PULSE_WIDTH_NS 12
`define DPR_WRITE_TURNOFF_NS     10
`define DPR_DATA_SETUP_NS        10
`define DPR_SELECT_TO_END_NS     12
`define DPR_FLAG_UPDATE_NS       10
`define DPR_FLAG_WR_TO_RD_NS     5
`define DPR_SLAVE_HOLD_NS        13
`define DPR_READ_ACCESS_NS       15
`define DPR_FAR_DATA_NS          30

// ----------------------------------------------------------------
// cycle counts, least times round up
// ----------------------------------------------------------------
`define DPR_CYC_UP(t) (((t) + `DPR_CLK_PERIOD_NS - 1) / `DPR_CLK_PERIOD_NS)
`define DPR_PULSE_OE_HI_CYC `DPR_CYC_UP(`DPR_WRITE_PULSE_WIDTH_NS)
`define DPR_PULSE_OE_LO_CYC \
    `DPR_CYC_UP(`DPR_WRITE_TURNOFF_NS + `DPR_DATA_SETUP_NS)
`define DPR_FLAG_UPDATE_CYC `DPR_CYC_UP(`DPR_FLAG_UPDATE_NS)
`define DPR_FLAG_WR_RD_CYC  `DPR_CYC_UP(`DPR_FLAG_WR_TO_RD_NS)
`define DPR_SLAVE_HOLD_CYC  `DPR_CYC_UP(`DPR_SLAVE_HOLD_NS)
`define DPR_READ_CYC        `DPR_CYC_UP(`DPR_READ_ACCESS_NS)
`define DPR_FAR_DATA_CYC    `DPR_CYC_UP(`DPR_FAR_DATA_NS)

`endif

/* dpr_pkg.sv */
// types for the dual-port memory host controller
package dpr_pkg;

    // ----------------------------------------------------------------
    // command kinds
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        DPR_CMD_READ,
        DPR_CMD_WRITE,
        DPR_CMD_TOKEN_GET,
        DPR_CMD_TOKEN_PUT
    } dpr_cmd_e;

    // ----------------------------------------------------------------
    // sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        DPR_IDLE,
        DPR_SETUP,
        DPR_PULSE,
        DPR_BUSY_WAIT,
        DPR_RECOVER,
        DPR_FLAG_GAP,
        DPR_READ,
        DPR_DONE
    } dpr_state_e;

endpackage

/* dpr_sync.sv */
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module dpr_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_b_i,
    // data
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            meta_r <= '0;
            q_o    <= '0;
        end else begin
            meta_r <= d_i;
            q_o    <= meta_r;
        end
    end
endmodule // dpr_sync

/* dual_port_ram_access_arbitration_tb.sv */
// self-checking bench for the dual-port memory host controller
`timescale 1ns/1ps
`include "dpr_params.svh"
module dual_port_ram_access_arbitration_tb;
    typedef struct packed {
        logic [1:0]  cmd;
        logic [13:0] addr;
        logic [15:0] wdata;
        logic [1:0]  bytes;
        logic        oe;
        logic        far;
        logic [15:0] exp;
    } dpr_row_s;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic req_valid_i = 1'b0;
    logic [1:0] req_cmd_i = 2'h0;
    logic [13:0] req_addr_i = 14'h0000;
    logic [15:0] req_wdata_i = 16'h0000;
    logic [1:0] req_bytes_i = 2'h0;
    logic req_oe_low_i = 1'b0;
    logic far_active = 1'b0;
    logic [13:0] far_addr = 14'h0000;
    logic [7:0] far_claim = 8'h08;
    logic req_ready_o, rsp_valid_o, rsp_token_o, busy_n_i;
    logic [15:0] rsp_rdata_o, data_o, data_oe_o, mdl_q;
    logic [13:0] addr_o, prev_a;
    logic chip_select_n_o, token_select_n_o, read_not_write_o;
    logic output_drive_n_o, high_byte_select_n_o, low_byte_select_n_o;
    logic prev_rw = 1'b1;
    logic prev_bz = 1'b1;
    logic oe_lo = 1'b0;
    logic bz = 1'b0;
    int fails = 0;
    int checks_done = 0;
    int lo_cyc = 0;
    realtime t_rel = 0.0;
    dpr_row_s rows [0:11];
    wire [15:0] pin = (data_oe_o & data_o) | (~data_oe_o & mdl_q);
    always #(`DPR_CLK_PERIOD_NS / 2.0) clk_i = ~clk_i;

    dpr_host dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .req_valid_i(req_valid_i),
        .req_ready_o(req_ready_o), .req_cmd_i(req_cmd_i), .req_addr_i(req_addr_i),
        .req_wdata_i(req_wdata_i), .req_bytes_i(req_bytes_i), .req_oe_low_i(req_oe_low_i),
        .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o), .rsp_token_o(rsp_token_o),
        .addr_o(addr_o), .chip_select_n_o(chip_select_n_o),
        .token_select_n_o(token_select_n_o), .read_not_write_o(read_not_write_o),
        .output_drive_n_o(output_drive_n_o), .high_byte_select_n_o(high_byte_select_n_o),
        .low_byte_select_n_o(low_byte_select_n_o), .data_o(data_o),
        .data_oe_o(data_oe_o), .data_i(pin), .busy_n_i(busy_n_i));
    dpr_mem_model mdl (.clk_i(clk_i), .addr_i(addr_o), .chip_select_n_i(chip_select_n_o),
        .token_select_n_i(token_select_n_o), .read_not_write_i(read_not_write_o),
        .output_drive_n_i(output_drive_n_o), .high_byte_select_n_i(high_byte_select_n_o),
        .low_byte_select_n_i(low_byte_select_n_o), .bus_i(pin), .q_o(mdl_q),
        .busy_n_o(busy_n_i), .far_active_i(far_active), .far_addr_i(far_addr),
        .far_claim_i(far_claim));

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic run_cmd(input dpr_row_s r);
        int n;
        @(negedge clk_i);
        {req_cmd_i, req_addr_i, req_wdata_i, req_bytes_i, req_oe_low_i} =
            {r.cmd, r.addr, r.wdata, r.bytes, r.oe};
        req_valid_i = 1'b1;
        for (n = 0; n < 50 && req_ready_o !== 1'b1; n++) @(negedge clk_i);
        @(negedge clk_i);
        req_valid_i = 1'b0;
        for (n = n; n < 150 && rsp_valid_o !== 1'b1; n++) @(negedge clk_i);
        if (n >= 150) begin
            fails++;
            summarize();
        end else begin
            if (r.cmd == 2'h0) check("read data", rsp_rdata_o, r.exp);
            if (r.cmd[1]) check("token owned", {15'h0, rsp_token_o}, r.exp);
            if (r.cmd[1]) check("token bit", {15'h0, rsp_rdata_o[0]}, {15'h0, ~r.exp[0]});
        end
    endtask

    task automatic idle_check();
        check("idle pins", {10'h0, chip_select_n_o, token_select_n_o, read_not_write_o,
            output_drive_n_o, high_byte_select_n_o, low_byte_select_n_o}, 16'h003f);
        check("idle strobes", {13'h0, req_ready_o, rsp_valid_o, |data_oe_o}, 16'h0004);
    endtask

    // pin monitor, looked at once the falling edge has settled
    always @(negedge clk_i) begin
        #1;
        if (rst_b_i && addr_o !== prev_a) check("rw on addr change", {15'h0, read_not_write_o}, 16'h1);
        if (rst_b_i && !read_not_write_o) begin
            lo_cyc++;
            oe_lo = oe_lo | !output_drive_n_o;
            bz = bz | !busy_n_i;
        end else if (lo_cyc > 0) begin
            if (!bz && rst_b_i) check("pulse length", {15'h0, lo_cyc * `DPR_CLK_PERIOD_NS >= (oe_lo ?
                `DPR_WRITE_TURNOFF_NS + `DPR_DATA_SETUP_NS : `DPR_WRITE_PULSE_WIDTH_NS)}, 16'h1);
            lo_cyc = 0;
            oe_lo = 1'b0;
            bz = 1'b0;
        end
        if (busy_n_i && !prev_bz) t_rel = $realtime;
        if (!read_not_write_o && prev_rw && t_rel > 0.0) begin
            check("rw hold after busy", {15'h0, $realtime - t_rel >= `DPR_SLAVE_HOLD_NS}, 16'h1);
            t_rel = 0.0;
        end
        prev_a = addr_o;
        prev_rw = read_not_write_o;
        prev_bz = busy_n_i;
    end

    initial begin
        rows[0] = '{2'h1, 14'h0005, 16'ha55a, 2'h3, 1'b0, 1'b0, 16'h0000};
        rows[1] = '{2'h0, 14'h0005, 16'h0000, 2'h3, 1'b0, 1'b0, 16'ha55a};
        rows[2] = '{2'h1, 14'h0005, 16'h1234, 2'h2, 1'b1, 1'b0, 16'h0000};
        rows[3] = '{2'h0, 14'h0005, 16'h0000, 2'h3, 1'b0, 1'b0, 16'h125a};
        rows[4] = '{2'h1, 14'h3fff, 16'hbeef, 2'h1, 1'b0, 1'b0, 16'h0000};
        rows[5] = '{2'h0, 14'h3fff, 16'h0000, 2'h3, 1'b0, 1'b0, 16'h00ef};
        rows[6] = '{2'h2, 14'h0002, 16'h0000, 2'h3, 1'b0, 1'b0, 16'h0001};
        rows[7] = '{2'h2, 14'h0003, 16'h0000, 2'h3, 1'b0, 1'b0, 16'h0000};
        rows[8] = '{2'h3, 14'h0002, 16'h0000, 2'h3, 1'b0, 1'b0, 16'h0000};
        rows[9] = '{2'h2, 14'h0002, 16'h0000, 2'h3, 1'b0, 1'b0, 16'h0001};
        rows[10] = '{2'h1, 14'h0010, 16'h0f0f, 2'h3, 1'b0, 1'b1, 16'h0000};
        rows[11] = '{2'h0, 14'h0010, 16'h0000, 2'h3, 1'b0, 1'b1, 16'h0f0f};
        repeat (6) @(negedge clk_i);
        idle_check();
        rst_b_i = 1'b1;
        foreach (rows[i]) begin
            if (rows[i].far) begin
                fork
                    begin
                        far_addr = rows[i].addr;
                        far_active = 1'b1;
                        repeat (8) @(negedge clk_i);
                        far_active = 1'b0;
                    end
                    run_cmd(rows[i]);
                join
            end else begin
                run_cmd(rows[i]);
            end
        end
        // reset in the middle of a write
        @(negedge clk_i);
        {req_cmd_i, req_addr_i, req_wdata_i, req_valid_i} = {2'h1, 14'h0020, 16'h7777, 1'b1};
        repeat (3) @(negedge clk_i);
        rst_b_i = 1'b0;
        req_valid_i = 1'b0;
        #1;
        idle_check();
        repeat (2) @(negedge clk_i);
        rst_b_i = 1'b1;
        run_cmd(rows[3]);
        summarize();
    end
endmodule // dual_port_ram_access_arbitration_tb
